// ===== rmch_defs.svh
`ifndef RMCH_DEFS_SVH
`define RMCH_DEFS_SVH

// Status register field positions.
`define RMCH_ST_SEL 5
`define RMCH_ST_CHAN 6
`define RMCH_ST_CHB 7
`define RMCH_ST_CHA 8
`define RMCH_ST_TERM_FLAG_ALLOWED_BIT 9
`define RMCH_ST_BUSY 10
`define RMCH_ST_SELF 11
`define RMCH_ST_TAPE 12
`define RMCH_ST_MERR 13
`define RMCH_ST_VMSG 14
`define RMCH_ST_ACTV 15

// Recent command register field positions.
`define RMCH_LC_BUSY 11
`define RMCH_LC_SELF 12
`define RMCH_LC_TERM_FLAG_ALLOWED_BIT 13
`define RMCH_LC_CHAN 14
`define RMCH_LC_ILL 15

// Reset values.
`define RMCH_LC_CMD_RST 11'h7FF

// Mode codes.
`define RMCH_MC_DBC 5'h00
`define RMCH_MC_SYNC 5'h01
`define RMCH_MC_TXST 5'h02
`define RMCH_MC_STEST 5'h03
`define RMCH_MC_TSD 5'h04
`define RMCH_MC_OTSD 5'h05
`define RMCH_MC_ITF 5'h06
`define RMCH_MC_OITF 5'h07
`define RMCH_MC_RRT 5'h08
`define RMCH_MC_VEC 5'h10
`define RMCH_MC_SYNCD 5'h11
`define RMCH_MC_TXLC 5'h12
`define RMCH_MC_BIT 5'h13
`define RMCH_MC_SSD 5'h14
`define RMCH_MC_OSSD 5'h15

// Memory block used for mode code data words.
`define RMCH_MC_BLOCK 1

`endif

// ===== rmch_pkg.sv
package rmch_pkg;

   // Decoded fields of one command word.
   typedef struct packed {
      logic [4:0] addr;
      logic tx;
      logic [4:0] sub;
      logic [4:0] count;
   } rmch_cmd_type;

   // Sequencer states, Gray coded along the main path.
   typedef enum logic [1:0] {
      RMCH_IDLE = 2'h0,
      RMCH_EXEC = 2'h1,
      RMCH_RESP = 2'h3
   } rmch_state_type;

endpackage

// ===== rmch_mode_code_handler.sv
`include "rmch_defs.svh"

// Contract
// - Sixteen-bit read-only status register with fields
// - Reset clears status except flag enable, channel
// - Valid bit latches until read, error until read without fault
// - Active bit is NAND of phase pins
// - Last command reply sends low eleven bits
// - Low eleven bits hold command, reset ones
// - Bit eleven mirrors busy, resets zero
// - Bit twelve mirrors self-test, resets zero
// - Bits thirteen, fourteen mirror flag, channel
// - Bit fifteen flags illegal command, resets one
// - Drive field and selector after decode
// - Reject listed and reserved mode codes
// - Illegal code: store, pin, latch, status
// - Mode codes with data move memory
// - Mode code data uses block one
// - No memory request for status, last command
// - Sync, self-test, reset only store, respond
// - Data words passed through uninterpreted
// - Shutdown disables, override enables alternate bus
// - Inhibit clears flag; override only enables
// - Last command reply keeps stored command
module rmch_mode_code_handler
   import rmch_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_NRST,
   input wire logic i_cmd_valid,
   input wire logic [15:0] i_cmd_word,
   input wire logic i_cmd_chan_a,
   input wire logic i_illegal_command_in,
   input wire logic i_transmit_phase_n,
   input wire logic i_receive_phase_n,
   input wire logic i_busy,
   input wire logic i_self_test,
   input wire logic i_address_parity_fault,
   input wire logic i_fault_cond,
   input wire logic i_msg_done_ok,
   input wire logic i_status_read,
   input wire logic i_chan_a_ctrl_en,
   input wire logic i_chan_b_ctrl_en,
   input wire logic i_resp_done,
   output logic [4:0] o_mode_subaddr_field,
   output logic o_mode_or_subaddr_sel,
   output logic o_broadcast_indication,
   output logic o_message_fault_out,
   output logic [15:0] o_terminal_status_reg,
   output logic [15:0] o_recent_command_reg,
   output logic o_mem_req,
   output logic o_mem_tx,
   output logic [4:0] o_mem_subaddr,
   output logic [4:0] o_mem_block,
   output logic o_send_status,
   output logic o_send_last_cmd,
   output logic [15:0] o_last_cmd_word,
   output logic o_term_flag_force_zero,
   output logic o_busy_applied
);

   rmch_cmd_type cmd;
   rmch_state_type state;
   rmch_state_type next_state;
   logic [4:0] field;
   logic sel;
   logic chan;
   logic cha_mc;
   logic chb_mc;
   logic term_flag_allowed_bit;
   logic merr;
   logic vmsg;
   logic actv;
   logic [10:0] lc_cmd;
   logic lc_ill;
   logic [4:0] own_addr;
   logic bcast;
   logic is_txlc_q;

   // Command word fields and mode code decode.
   wire rmch_cmd_type in_cmd = i_cmd_word;
   wire is_mode = (in_cmd.sub == 5'h00) || (in_cmd.sub == 5'h1F);
   wire [4:0] code = in_cmd.count;
   wire known_tx = (code == `RMCH_MC_SYNC) || (code == `RMCH_MC_TXST) || (code == `RMCH_MC_STEST)
      || (code == `RMCH_MC_TSD) || (code == `RMCH_MC_OTSD) || (code == `RMCH_MC_ITF)
      || (code == `RMCH_MC_OITF) || (code == `RMCH_MC_RRT) || (code == `RMCH_MC_VEC)
      || (code == `RMCH_MC_TXLC) || (code == `RMCH_MC_BIT);
   wire known_rx = (code == `RMCH_MC_SYNCD);
   // Dynamic bus control, selected shutdown pair and reserved codes fall out as illegal.
   wire int_illegal = is_mode && !(in_cmd.tx ? known_tx : known_rx);
   wire illegal = int_illegal || i_illegal_command_in;
   wire is_txlc = is_mode && in_cmd.tx && (code == `RMCH_MC_TXLC);
   wire is_txst = is_mode && in_cmd.tx && (code == `RMCH_MC_TXST);
   // Data carrying codes are those with the top bit set; status and last command are internal.
   wire mc_data = is_mode && code[4] && !is_txlc;
   wire need_mem = !illegal && !i_busy && (is_mode ? mc_data : 1'b1);
   // Alternate bus is the channel that did not carry this command.
   wire tsd = is_mode && in_cmd.tx && !illegal && (code == `RMCH_MC_TSD);
   wire otsd = is_mode && in_cmd.tx && !illegal && (code == `RMCH_MC_OTSD);
   wire itf = is_mode && in_cmd.tx && !illegal && (code == `RMCH_MC_ITF);
   wire oitf = is_mode && in_cmd.tx && !illegal && (code == `RMCH_MC_OITF);
   wire take = (state == RMCH_IDLE) && i_cmd_valid;

   // Sequencer: take a command, act on it, wait for the response to finish.
   always_comb
   begin
      next_state = state;
      case (state)
         RMCH_IDLE:
         begin
            if (i_cmd_valid)
               next_state = RMCH_EXEC;
         end
         RMCH_EXEC:
            next_state = RMCH_RESP;
         RMCH_RESP:
         begin
            if (i_resp_done)
               next_state = RMCH_IDLE;
         end
         default:
            next_state = RMCH_IDLE;
      endcase
   end

   always_ff @(posedge I_CLK)
   begin
      if (!I_NRST)
         state <= RMCH_IDLE;
      else
         state <= next_state;
   end

   // Captured command, field outputs and stored last command.
   always_ff @(posedge I_CLK)
   begin
      if (!I_NRST)
      begin
         cmd <= '0;
         field <= 5'h00;
         sel <= 1'b0;
         chan <= 1'b1;
         lc_cmd <= `RMCH_LC_CMD_RST;
         lc_ill <= 1'b1;
         bcast <= 1'b0;
      end
      else if (take)
      begin
         cmd <= in_cmd;
         field <= is_mode ? code : in_cmd.sub;
         sel <= !is_mode;
         chan <= i_cmd_chan_a;
         bcast <= (in_cmd.addr == 5'h1F);
         if (!is_txlc || illegal)
         begin
            lc_cmd <= i_cmd_word[10:0];
            lc_ill <= illegal;
         end
      end
   end

   // Channel enables and terminal flag enable driven by mode codes.
   always_ff @(posedge I_CLK)
   begin
      if (!I_NRST)
      begin
         cha_mc <= 1'b1;
         chb_mc <= 1'b1;
         term_flag_allowed_bit <= 1'b1;
      end
      else if (take)
      begin
         if (tsd)
         begin
            if (i_cmd_chan_a)
               chb_mc <= 1'b0;
            else
               cha_mc <= 1'b0;
         end
         else if (otsd)
         begin
            if (i_cmd_chan_a)
               chb_mc <= 1'b1;
            else
               cha_mc <= 1'b1;
         end
         if (itf)
            term_flag_allowed_bit <= 1'b0;
         else if (oitf)
            term_flag_allowed_bit <= 1'b1;
      end
   end

   // Message error and valid message latches; a new event beats the read clear.
   wire merr_set = (take && illegal) || i_address_parity_fault;
   wire vmsg_set = i_msg_done_ok;
   always_ff @(posedge I_CLK)
   begin
      if (!I_NRST)
      begin
         merr <= 1'b0;
         vmsg <= 1'b0;
         actv <= 1'b0;
      end
      else
      begin
         merr <= merr_set || (merr && !(i_status_read && !i_fault_cond));
         vmsg <= vmsg_set || (vmsg && !i_status_read);
         actv <= ~(i_transmit_phase_n & i_receive_phase_n);
      end
   end

   // Memory request, response strobes and pin outputs.
   always_ff @(posedge I_CLK)
   begin
      if (!I_NRST)
      begin
         o_mem_req <= 1'b0;
         o_mem_tx <= 1'b0;
         o_mem_subaddr <= 5'h00;
         o_mem_block <= 5'h00;
         o_send_status <= 1'b0;
         o_send_last_cmd <= 1'b0;
         o_message_fault_out <= 1'b0;
         o_term_flag_force_zero <= 1'b0;
         own_addr <= 5'h00;
      end
      else
      begin
         o_mem_req <= take && need_mem;
         if (take)
         begin
            o_mem_tx <= in_cmd.tx;
            o_mem_subaddr <= in_cmd.sub;
            o_mem_block <= is_mode ? 5'(`RMCH_MC_BLOCK) : in_cmd.count;
            own_addr <= in_cmd.addr;
         end
         o_send_status <= (state == RMCH_EXEC);
         // The reply does not depend on whether the previously stored command was illegal.
         o_send_last_cmd <= (state == RMCH_EXEC) && is_txlc_q;
         o_message_fault_out <= merr_set || (o_message_fault_out && state != RMCH_IDLE);
         if (take && itf)
            o_term_flag_force_zero <= 1'b1;
         else if (take && oitf)
            o_term_flag_force_zero <= 1'b0;
      end
   end

   // Transmit last command was taken in this exchange.
   always_ff @(posedge I_CLK)
   begin
      if (!I_NRST)
         is_txlc_q <= 1'b0;
      else if (take)
         is_txlc_q <= is_txlc && !illegal;
   end

   // Register images seen by the host.
   wire [15:0] status_img = {actv, vmsg, merr, i_address_parity_fault, i_self_test, i_busy, term_flag_allowed_bit,
      i_chan_a_ctrl_en & cha_mc, i_chan_b_ctrl_en & chb_mc, chan, sel, field};
   wire [15:0] recent_img = {lc_ill, chan, term_flag_allowed_bit, i_self_test, i_busy, lc_cmd};
   always_ff @(posedge I_CLK)
   begin
      if (!I_NRST)
      begin
         o_terminal_status_reg <= 16'h0240;
         o_recent_command_reg <= 16'hE7FF;
         o_mode_subaddr_field <= 5'h00;
         o_mode_or_subaddr_sel <= 1'b0;
         o_broadcast_indication <= 1'b0;
         o_last_cmd_word <= 16'h0000;
         o_busy_applied <= 1'b0;
      end
      else
      begin
         o_terminal_status_reg <= status_img;
         o_recent_command_reg <= recent_img;
         o_mode_subaddr_field <= field;
         o_mode_or_subaddr_sel <= sel;
         o_broadcast_indication <= bcast;
         o_last_cmd_word <= {own_addr, recent_img[10:0]};
         o_busy_applied <= i_busy;
      end
   end

endmodule

// ===== rmch_bc_model.sv
module rmch_bc_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic send_status,
   input wire logic slow,
   output logic resp_done,
   output logic tx_phase_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt;
   // The reply is framed by the transmit phase and ends promptly or slowly.
   always @(posedge clk)
   begin
      if (!nrst)
         cnt <= 4'h0;
      else if (send_status)
         cnt <= slow ? 4'h9 : 4'h2;
      else if (cnt != 4'h0)
         cnt <= cnt - 4'h1;
      resp_done <= nrst && cnt == 4'h1;
      tx_phase_n <= !(nrst && cnt != 4'h0);
   end
endmodule

// ===== rmch_checker.sv
module rmch_checker (
   input wire logic I_CLK,
   input wire logic I_NRST,
   input wire logic i_cmd_valid,
   input wire logic [15:0] i_cmd_word,
   input wire logic i_transmit_phase_n,
   input wire logic i_receive_phase_n,
   input wire logic i_busy,
   input wire logic [4:0] o_mode_subaddr_field,
   input wire logic o_mode_or_subaddr_sel,
   input wire logic [15:0] o_terminal_status_reg,
   input wire logic [15:0] o_recent_command_reg,
   input wire logic o_mem_req,
   input wire logic [4:0] o_mem_block,
   input wire logic o_send_status,
   input wire logic o_send_last_cmd
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_NRST);
   logic [15:0] prev_cmd;
   wire logic [15:0] st = o_terminal_status_reg;
   wire logic [15:0] lc = o_recent_command_reg;
   wire logic prev_mode = prev_cmd[9:5] == 5'h00 || prev_cmd[9:5] == 5'h1F;
   // Keeps the word of the previous cycle, since the memory request follows it by one edge.
   always_ff @(posedge I_CLK)
   begin
      prev_cmd <= i_cmd_word;
   end
   act_bit_a: assert property ($past(I_NRST, 2) |-> st[15] == !($past(i_transmit_phase_n, 2) && $past(i_receive_phase_n, 2)))
      else $error("active bit wrong");
   busy_bit_a: assert property ($past(I_NRST) |-> st[10] == $past(i_busy))
      else $error("busy bit wrong");
   lc_mirror_a: assert property (lc[14:11] == {st[6], st[9], st[11], st[10]})
      else $error("recent command mirror wrong");
   field_sel_a: assert property (st[5:0] == {o_mode_or_subaddr_sel, o_mode_subaddr_field})
      else $error("status field differs from pins");
   req_cause_a: assert property (o_mem_req |-> $past(i_cmd_valid))
      else $error("memory request without command");
   reply_time_a: assert property (o_send_status |-> $past(i_cmd_valid, 2))
      else $error("status reply out of time");
   last_reply_a: assert property (o_send_last_cmd |-> o_send_status && !o_mode_or_subaddr_sel)
      else $error("last command reply wrong");
   mode_block_a: assert property (o_mem_req && prev_mode |-> o_mem_block == 5'h01)
      else $error("mode data block wrong");
   no_req_a: assert property (o_mem_req && prev_mode |-> prev_cmd[4:0] != 5'h02 && prev_cmd[4:0] != 5'h12)
      else $error("memory request for internal reply");
endmodule
bind rmch_mode_code_handler rmch_checker chk_u (.*);

// ===== testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, nrst, vld, chan, ext, rxn, busy, slf, fcond, okp, rd, slow, done, txn, sel, merr, req, snd, sndl, fz;
   logic [15:0] cw, st, lc, lw;
   logic [4:0] fld;
   logic [31:0] lfsr = 32'hBFC1E9E3;
   logic [10:0] elc = 11'h7FF;
   logic eil = 1'b1;
   logic etf = 1'b1;
   int bad_count = 0;
   int samples_checked = 0;
   rmch_mode_code_handler dut_u (.I_CLK(clk), .I_NRST(nrst), .i_cmd_valid(vld), .i_cmd_word(cw),
      .i_cmd_chan_a(chan), .i_illegal_command_in(ext), .i_transmit_phase_n(txn), .i_receive_phase_n(rxn),
      .i_busy(busy), .i_self_test(slf), .i_address_parity_fault(1'b0), .i_fault_cond(fcond),
      .i_msg_done_ok(okp), .i_status_read(rd), .i_chan_a_ctrl_en(1'b1), .i_chan_b_ctrl_en(1'b1),
      .i_resp_done(done), .o_mode_subaddr_field(fld), .o_mode_or_subaddr_sel(sel), .o_broadcast_indication(),
      .o_message_fault_out(merr), .o_terminal_status_reg(st), .o_recent_command_reg(lc), .o_mem_req(req),
      .o_mem_tx(), .o_mem_subaddr(), .o_mem_block(), .o_send_status(snd), .o_send_last_cmd(sndl),
      .o_last_cmd_word(lw), .o_term_flag_force_zero(fz), .o_busy_applied());
   rmch_bc_model bc_u (.clk(clk), .nrst(nrst), .send_status(snd), .slow(slow), .resp_done(done), .tx_phase_n(txn));
   // Makes the 50 ns clock.
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // Tells whether the terminal itself refuses a command word.
   function automatic logic ill(input logic [15:0] w);
      return (w[9:5] == 5'h00 || w[9:5] == 5'h1F) && ((w[10] && w[4:0] == 5'h00) || (!w[10] && w[4:1] == 4'hA)
         || (w[4:0] > 5'h08 && w[4:0] < 5'h10) || w[4:0] > 5'h15);
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
         bad_count++;
      end
   endtask
   task tick;
      @(posedge clk);
      #1;
   endtask
   task print_verdict;
      if (bad_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Sends one command, checks the answer over the next two cycles, then waits for the response to end.
   task automatic send(input logic [15:0] w, input logic c, input logic e);
      logic md, il, lcmd;
      md = w[9:5] == 5'h00 || w[9:5] == 5'h1F;
      il = ill(w);
      lcmd = md && w[10] && w[4:0] == 5'h12;
      vld = 1'b1;
      cw = w;
      chan = c;
      ext = e;
      tick;
      vld = 1'b0;
      if (!il && !e) chk(req, !busy && (!md || (w[4] && w[4:0] != 5'h12)));
      if (il || e) chk(req, 1'b0);
      if (!e) chk(merr, il);
      tick;
      if (!lcmd)
      begin
         elc = w[10:0];
         eil = il | e;
      end
      if (md && w[10] && w[4:1] == 4'h3) etf = w[0];
      chk(snd, 1'b1);
      chk(sndl, lcmd);
      chk({lc[15], lc[10:0]}, {eil, elc});
      chk({st[9], st[5:0]}, {etf, !md, md ? w[4:0] : w[9:5]});
      chk(fz, !etf);
      if (il) chk(st[13], 1'b1);
      if (lcmd) chk(lw, {w[15:11], elc});
      for (int i = 0; i < 20 && !done; i++) tick;
      if (!done)
      begin
         bad_count++;
         print_verdict;
      end
      tick;
   endtask
   // Main sequence: every mode code, refusals, latch clearing, then random traffic.
   initial
   begin
      {vld, cw, chan, ext, busy, slf, fcond, okp, rd, slow, nrst} = '0;
      rxn = 1'b1;
      tick;
      tick;
      nrst = 1'b1;
      chk(st, 16'h0240);
      chk(lc, 16'hE7FF);
      for (int m = 0; m < 32; m++) send({5'h03, !(m == 17 || m == 20 || m == 21), 5'h00, m[4:0]}, m[0], 1'b0);
      okp = 1'b1;
      fcond = 1'b1;
      rd = 1'b1;
      tick;
      okp = 1'b0;
      tick;
      chk(st[14:13], 2'h3);
      fcond = 1'b0;
      tick;
      rd = 1'b0;
      tick;
      chk(st[14:13], 2'h0);
      send(16'h1A22, 1'b1, 1'b1);
      for (int n = 0; n < 40; n++)
      begin
         lfsr = nxt(lfsr);
         {busy, slf, rxn, slow} = lfsr[26:23];
         send({lfsr[15:10], 5'h01 + {1'b0, lfsr[19:16]}, lfsr[4:0]}, lfsr[7], 1'b0);
      end
      print_verdict;
   end
endmodule
